/* src/pms_edge_sampler.sv */
// three-stage pin sampler with clock edge finder and pre-edge data
`timescale 1ns/1ps
`default_nettype none
module pms_edge_sampler import pms_pkg::*; (
   // core
   input wire logic clk,
   input wire logic rst,
   // pins from another domain
   input wire logic link_clk,
   input wire logic [`PMS_SMP_W-1:0] link_data,
   // results
   output logic rise,
   output logic fall,
   output logic [`PMS_SMP_W-1:0] pre,
   output logic [`PMS_SMP_W-1:0] level
);
   pms_smp_t s;
   pms_smp_t next_s;
   logic agree;
   logic edge_seen;
   logic [`PMS_SMP_W-1:0] diff;

   // edge counts once second and third stage agree on a new level
   always_comb begin
      next_s = s;
      next_s.clk_sh = {s.clk_sh[1:0], link_clk};
      next_s.d1 = link_data;
      next_s.d2 = s.d1;
      next_s.d3 = s.d2;
      next_s.d4 = s.d3; // one sample older: value held before the edge
      agree = (s.clk_sh[1] == s.clk_sh[2]);
      edge_seen = agree && (s.clk_sh[2] != s.clk_lvl);
      if (edge_seen) begin
         next_s.clk_lvl = s.clk_sh[2];
      end
      diff = s.d2 ^ s.d3;
      next_s.dlvl = (s.d3 & ~diff) | (s.dlvl & diff);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // pulses are combinational; pre stays valid during the pulse
   assign rise = edge_seen && s.clk_sh[2];
   assign fall = edge_seen && !s.clk_sh[2];
   assign pre = s.d4;
   assign level = s.dlvl;
endmodule : pms_edge_sampler
`default_nettype wire

/* src/pms_link_if.sv */
// pin bundle between the transceiver end and the controller end
`timescale 1ns/1ps
`default_nettype none
interface pms_link_if;
   logic rx_clk;
   logic [7:0] rxd;
   logic rx_ctrl;
   logic rx_err;
   logic col;
   logic crs;
   logic tx_clk;
   logic gtx_clk;
   logic tx_ctrl;

   modport phy (
      output rx_clk, rxd, rx_ctrl, rx_err, col, crs, tx_clk,
      input gtx_clk, tx_ctrl
   );

   modport mac (
      input rx_clk, rxd, rx_ctrl, rx_err, col, crs, tx_clk,
      output gtx_clk, tx_ctrl
   );
endinterface : pms_link_if
`default_nettype wire

/* src/pms_mac_end.sv */
// controller end: transmit clock and control, receive capture, COL/CRS
`timescale 1ns/1ps
`default_nettype none
module pms_mac_end import pms_pkg::*; (
   // core clock and reset
   input wire logic CLK,
   input wire logic RST,
   // operating mode
   input wire pms_mode_t MODE,
   input wire pms_speed_t SPEED,
   input wire logic FULL_DUPLEX,
   // transmit request
   input wire logic TX_VALID,
   input wire logic TX_ERROR,
   output logic TX_TAKE,
   // received bytes
   output logic [7:0] RX_DATA,
   output logic RX_VALID,
   output logic RX_ERROR,
   output logic RX_STROBE,
   // synchronised line status
   output logic COL,
   output logic CRS,
   // pins toward the transceiver
   pms_link_if.mac LINK
);
   pms_mac_t s;
   pms_mac_t next_s;
   logic tick;
   logic rgmii;
   logic nib_mode;
   logic launch_r;
   logic launch_f;
   logic ev;
   logic ev_dv;
   logic ev_er;
   logic [7:0] ev_byte;
   logic [3:0] ev_nib;
   logic r_rise;
   logic r_fall;
   logic c_fall;
   logic [`PMS_SMP_W-1:0] r_pre;
   logic [`PMS_SMP_W-1:0] r_data;
   logic [`PMS_SMP_W-1:0] cs_data;
   logic [`PMS_SMP_W-1:0] cs_lvl;

   assign r_data = {LINK.rx_err, LINK.rx_ctrl, LINK.rxd};
   assign cs_data = {{(`PMS_SMP_W-2){1'b0}}, LINK.crs, LINK.col};

   // receive pins, timed by the transceiver's clock
   pms_edge_sampler u_rx_smp (
      .clk(CLK),
      .rst(RST),
      .link_clk(LINK.rx_clk),
      .link_data(r_data),
      .rise(r_rise),
      .fall(r_fall),
      .pre(r_pre),
      .level()
   );

   // MII transmit clock edges
   pms_edge_sampler u_tc_smp (
      .clk(CLK),
      .rst(RST),
      .link_clk(LINK.tx_clk),
      .link_data('0),
      .rise(),
      .fall(c_fall),
      .pre(),
      .level()
   );

   // asynchronous status pins, level only
   pms_edge_sampler u_cs_smp (
      .clk(CLK),
      .rst(RST),
      .link_clk(1'b0),
      .link_data(cs_data),
      .rise(),
      .fall(),
      .pre(),
      .level(cs_lvl)
   );

   always_comb begin
      next_s = s;
      next_s.take = 1'b0;
      next_s.strobe = 1'b0;
      rgmii = (MODE == PMS_RGMII);
      nib_mode = pms_nibble_mode(MODE, SPEED);
      launch_r = 1'b0;
      launch_f = 1'b0;

      // free-running transmit clock divider
      tick = (s.cnt == '0);
      if (tick) begin
         next_s.cnt = pms_half_count(SPEED) - `PMS_CNT_W'(1);
      end else begin
         next_s.cnt = s.cnt - `PMS_CNT_W'(1);
      end
      if (MODE == PMS_MII) begin
         next_s.gtx = 1'b0;
         launch_r = c_fall;
      end else if (tick) begin
         next_s.gtx = !s.gtx;
         launch_r = s.gtx;
         launch_f = !s.gtx && rgmii;
      end
      if (launch_r) begin
         next_s.tx_en = TX_VALID;
         next_s.tx_er = TX_VALID && TX_ERROR;
         next_s.tx_ctrl = TX_VALID;
         next_s.take = TX_VALID;
      end
      if (launch_f) begin
         next_s.tx_ctrl = s.tx_en ^ s.tx_er;
      end

      // receive: rising sample holds low nibble and valid
      if (r_rise) begin
         next_s.rlo = r_pre[3:0];
         next_s.rdv = r_pre[`PMS_SMP_CTRL];
         next_s.rer = r_pre[`PMS_SMP_ERR];
      end
      if (rgmii) begin
         ev = r_fall;
         ev_dv = s.rdv;
         ev_er = s.rdv ^ r_pre[`PMS_SMP_CTRL];
         ev_byte = {r_pre[3:0], s.rlo};
         ev_nib = s.rlo;
      end else begin
         ev = r_rise;
         ev_dv = r_pre[`PMS_SMP_CTRL];
         ev_er = r_pre[`PMS_SMP_ERR];
         ev_byte = (MODE == PMS_GMII) ? r_pre[7:0] : {4'h0, r_pre[3:0]};
         ev_nib = r_pre[3:0];
      end
      if (ev) begin
         next_s.valid = ev_dv;
         next_s.err = ev_er;
         if (!nib_mode) begin
            next_s.data = ev_byte;
            next_s.strobe = ev_dv;
         end else if (!ev_dv) begin
            // odd nibble at frame end is dropped
            next_s.nib = PMS_NIB_LO;
         end else if (s.nib == PMS_NIB_LO) begin
            next_s.plo = ev_nib;
            next_s.nib = PMS_NIB_HI;
         end else begin
            next_s.data = {ev_nib, s.plo};
            next_s.strobe = 1'b1;
            next_s.nib = PMS_NIB_LO;
         end
      end

      // status pins are synchronised before use
      next_s.col = !rgmii && cs_lvl[`PMS_SMP_COL];
      next_s.crs = !rgmii && cs_lvl[`PMS_SMP_CRS]
         && !(FULL_DUPLEX && SPEED == PMS_S1000);
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign LINK.gtx_clk = s.gtx;
   assign LINK.tx_ctrl = s.tx_ctrl;
   assign TX_TAKE = s.take;
   assign RX_DATA = s.data;
   assign RX_VALID = s.valid;
   assign RX_ERROR = s.err;
   assign RX_STROBE = s.strobe;
   assign COL = s.col;
   assign CRS = s.crs;
endmodule : pms_mac_end
`default_nettype wire

/* src/pms_params.svh */
// timing counts and field positions shared by both ends of the link
`ifndef PMS_PARAMS_SVH
`define PMS_PARAMS_SVH

// core clock and printed link clock periods
`define PMS_CLK_MHZ 32'h0000_0064
`define PMS_NS_PER_US 32'h0000_03E8
`define PMS_RXCLK_NS_10 32'h0000_0190
`define PMS_RXCLK_NS_100 32'h0000_0028
`define PMS_RXCLK_NS_1000 32'h0000_0008

// half-period counts in core cycles, floor of the exact figure
`define PMS_HALF_10 ((`PMS_RXCLK_NS_10 * `PMS_CLK_MHZ) / (2 * `PMS_NS_PER_US))
`define PMS_HALF_100 ((`PMS_RXCLK_NS_100 * `PMS_CLK_MHZ) / (2 * `PMS_NS_PER_US))
`define PMS_HALF_1000 ((`PMS_RXCLK_NS_1000 * `PMS_CLK_MHZ) / (2 * `PMS_NS_PER_US))
// edge finder needs two equal samples, so no half period may be shorter
`define PMS_MIN_HALF 32'h0000_0002
`define PMS_CNT_W 6

// sampler data layout
`define PMS_SMP_W 10
`define PMS_SMP_CTRL 8
`define PMS_SMP_ERR 9
`define PMS_SMP_COL 0
`define PMS_SMP_CRS 1

`endif

/* src/pms_phy_end.sv */
// transceiver end: receive launch, transmit control decode, COL and CRS
`timescale 1ns/1ps
`default_nettype none
module pms_phy_end import pms_pkg::*; (
   // core clock and reset
   input wire logic CLK,
   input wire logic RST,
   // operating mode
   input wire pms_mode_t MODE,
   input wire pms_speed_t SPEED,
   input wire logic FULL_DUPLEX,
   // receive bytes from the line side
   input wire logic [7:0] RX_DATA,
   input wire logic RX_VALID,
   input wire logic RX_ERROR,
   output logic RX_TAKE,
   // line activity
   input wire logic LINE_CARRIER,
   // decoded transmit control
   output logic TX_ACTIVE,
   output logic TX_ERROR,
   // pins toward the controller
   pms_link_if.phy LINK
);
   pms_phy_t s;
   pms_phy_t next_s;
   logic tick;
   logic nib_mode;
   logic rgmii;
   logic half_dup;
   logic rx_act;
   logic samp_clk;
   logic t_rise;
   logic t_fall;
   logic [`PMS_SMP_W-1:0] t_pre;
   logic [`PMS_SMP_W-1:0] t_data;

   // MII transmit is timed by our own clock, sent through the same
   // sampler so that clock and enable see equal delay
   assign samp_clk = (MODE == PMS_MII) ? s.tclk : LINK.gtx_clk;
   assign t_data = {{(`PMS_SMP_W-1){1'b0}}, LINK.tx_ctrl};

   pms_edge_sampler u_tx_smp (
      .clk(CLK),
      .rst(RST),
      .link_clk(samp_clk),
      .link_data(t_data),
      .rise(t_rise),
      .fall(t_fall),
      .pre(t_pre),
      .level()
   );

   // next-state logic for the whole end
   always_comb begin
      next_s = s;
      next_s.take = 1'b0;
      rgmii = (MODE == PMS_RGMII);
      nib_mode = pms_nibble_mode(MODE, SPEED);
      half_dup = !FULL_DUPLEX;

      // clock divider: one tick per half period of the receive clock
      tick = (s.cnt == '0);
      if (tick) begin
         next_s.cnt = pms_half_count(SPEED) - `PMS_CNT_W'(1);
      end else begin
         next_s.cnt = s.cnt - `PMS_CNT_W'(1);
      end

      if (tick) begin
         next_s.rclk = !s.rclk;
         // MII transmit clock runs at the receive rate
         next_s.tclk = !s.rclk && (MODE == PMS_MII);
         if (s.rclk) begin
            // falling edge: launch what the next rising edge samples
            if (nib_mode && s.nib == PMS_NIB_HI) begin
               next_s.rxd = {4'h0, s.byte_q[7:4]};
               next_s.nib = PMS_NIB_LO;
            end else if (RX_VALID) begin
               next_s.byte_q = RX_DATA;
               next_s.dv = 1'b1;
               next_s.er = RX_ERROR;
               next_s.take = 1'b1;
               next_s.nib = nib_mode ? PMS_NIB_HI : PMS_NIB_LO;
               if (MODE == PMS_GMII) begin
                  next_s.rxd = RX_DATA;
               end else begin
                  next_s.rxd = {4'h0, RX_DATA[3:0]};
               end
            end else begin
               // idle: error alone marks a false carrier, data zeroed
               next_s.byte_q = 8'h00;
               next_s.dv = 1'b0;
               next_s.er = RX_ERROR;
               next_s.nib = PMS_NIB_LO;
               next_s.rxd = 8'h00;
            end
            // rising sample of the control pin carries valid alone
            next_s.rx_ctrl = next_s.dv;
            // separate error pin stays low in RGMII
            next_s.rx_err = !rgmii && next_s.er;
         end else if (rgmii) begin
            // rising edge: launch what the falling edge samples
            next_s.rx_ctrl = s.dv ^ s.er;
            if (!nib_mode) begin
               next_s.rxd = {4'h0, s.byte_q[7:4]};
            end
         end
      end

      // transmit control decode from pre-edge samples
      if (t_rise) begin
         next_s.tx_en = t_pre[0];
         if (!rgmii) begin
            next_s.tx_err = 1'b0;
         end
      end
      if (t_fall && rgmii) begin
         // falling sample is enable xor error
         next_s.tx_err = t_pre[0] ^ s.tx_en;
      end

      // carrier and collision, from core clock, tied to no link clock
      rx_act = LINE_CARRIER || s.dv;
      next_s.col = !rgmii && half_dup && rx_act && s.tx_en;
      if (rgmii) begin
         next_s.crs = 1'b0;
      end else if (half_dup) begin
         next_s.crs = rx_act || s.tx_en;
      end else begin
         // gigabit full duplex carrier has no meaning: held low
         next_s.crs = (SPEED != PMS_S1000) && rx_act;
      end
   end

   // single state register
   always_ff @(posedge CLK) begin
      if (RST) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // pins and user outputs, all straight from flops
   assign LINK.rx_clk = s.rclk;
   assign LINK.tx_clk = s.tclk;
   assign LINK.rxd = s.rxd;
   assign LINK.rx_ctrl = s.rx_ctrl;
   assign LINK.rx_err = s.rx_err;
   assign LINK.col = s.col;
   assign LINK.crs = s.crs;
   assign RX_TAKE = s.take;
   assign TX_ACTIVE = s.tx_en;
   assign TX_ERROR = s.tx_err;
endmodule : pms_phy_end
`default_nettype wire

/* src/pms_pkg.sv */
// types and helpers shared by both link ends
`default_nettype none
package pms_pkg;
`include "pms_params.svh"

   typedef enum logic [1:0] {PMS_MII, PMS_GMII, PMS_RGMII} pms_mode_t;
   typedef enum logic [1:0] {PMS_S10, PMS_S100, PMS_S1000} pms_speed_t;
   typedef enum logic {PMS_NIB_LO, PMS_NIB_HI} pms_nib_t;

   // sampler state: clock shift, filtered clock, data stages
   typedef struct packed {
      logic [2:0] clk_sh;
      logic clk_lvl;
      logic [`PMS_SMP_W-1:0] d1;
      logic [`PMS_SMP_W-1:0] d2;
      logic [`PMS_SMP_W-1:0] d3;
      logic [`PMS_SMP_W-1:0] d4;
      logic [`PMS_SMP_W-1:0] dlvl;
   } pms_smp_t;

   // device end state
   typedef struct packed {
      logic [`PMS_CNT_W-1:0] cnt;
      logic rclk;
      logic tclk;
      logic [7:0] rxd;
      logic rx_ctrl;
      logic rx_err;
      logic [7:0] byte_q;
      logic dv;
      logic er;
      pms_nib_t nib;
      logic take;
      logic col;
      logic crs;
      logic tx_en;
      logic tx_err;
   } pms_phy_t;

   // controller end state
   typedef struct packed {
      logic [`PMS_CNT_W-1:0] cnt;
      logic gtx;
      logic tx_ctrl;
      logic tx_en;
      logic tx_er;
      logic take;
      logic [3:0] rlo;
      logic rdv;
      logic rer;
      logic [3:0] plo;
      pms_nib_t nib;
      logic [7:0] data;
      logic valid;
      logic err;
      logic strobe;
      logic col;
      logic crs;
   } pms_mac_t;

   // half period of the link clock for a speed, in core cycles
   function automatic logic [`PMS_CNT_W-1:0] pms_half_count(
      input pms_speed_t sp);
      int c;
      case (sp)
         PMS_S10: c = `PMS_HALF_10;
         PMS_S100: c = `PMS_HALF_100;
         default: c = `PMS_HALF_1000;
      endcase
      if (c < `PMS_MIN_HALF) begin
         c = `PMS_MIN_HALF;
      end
      return `PMS_CNT_W'(c);
   endfunction : pms_half_count

   // nibble-wide data: MII always, RGMII below gigabit
   function automatic logic pms_nibble_mode(input pms_mode_t m,
      input pms_speed_t sp);
      return (m == PMS_MII) || (m == PMS_RGMII && sp != PMS_S1000);
   endfunction : pms_nibble_mode

endpackage : pms_pkg
`default_nettype wire

/* verification/pms_link_assertions.sv */
// concurrent checks on the pins between the two link ends
`timescale 1ns/1ps
`default_nettype none
module pms_link_assertions import pms_pkg::*; (
   // core clock and reset
   input wire logic CLK,
   input wire logic RST,
   // operating mode shared by both ends
   input wire pms_mode_t MODE,
   input wire pms_speed_t SPEED,
   input wire logic FULL_DUPLEX,
   // link pins
   input wire logic rx_clk,
   input wire logic [7:0] rxd,
   input wire logic rx_ctrl,
   input wire logic rx_err,
   input wire logic col,
   input wire logic crs,
   input wire logic tx_clk,
   input wire logic gtx_clk,
   input wire logic tx_ctrl
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);

   logic [5:0] run;
   logic seen;
   logic [5:0] half;

   // expected receive clock half period in core cycles
   assign half = (SPEED == PMS_S10) ? 6'h14 : 6'h02;

   // length of the current receive clock level; the first level is
   // skipped since its phase after reset is the divider's own choice
   always_ff @(posedge CLK) begin
      if (RST) begin
         run <= 6'h00;
         seen <= 1'b0;
      end else if ($changed(rx_clk)) begin
         run <= 6'h00;
         seen <= 1'b1;
      end else begin
         run <= run + 6'h01;
      end
   end

   // one step of the receive clock and of the gtx clock
   sequence rx_edge;
      $changed(rx_clk);
   endsequence
   sequence gtx_edge;
      $changed(gtx_clk);
   endsequence

   a_rx_launch_sync: assert property ($changed(rxd) || $changed(rx_ctrl)
      |-> rx_edge) else $error("receive pins moved off a clock edge");
   a_tx_ctrl_sync: assert property ((MODE != PMS_MII) && $changed(tx_ctrl)
      |-> gtx_edge) else $error("tx control moved off gtx edge");
   a_rxd_high_zero: assert property ((MODE != PMS_GMII) |-> (rxd[7:4] == 4'h0))
      else $error("upper data bits driven outside gmii");
   a_rx_err_rgmii: assert property ((MODE == PMS_RGMII) |-> !rx_err)
      else $error("error pin driven in rgmii");
   a_col_quiet: assert property (FULL_DUPLEX || (MODE == PMS_RGMII) |-> !col)
      else $error("collision in full duplex or rgmii");
   a_crs_quiet: assert property ((MODE == PMS_RGMII) || (FULL_DUPLEX &&
      (SPEED == PMS_S1000)) |-> !crs) else $error("carrier not quiet");
   a_col_in_crs: assert property (col |-> crs)
      else $error("collision without carrier");
   a_rx_clk_half: assert property (seen && $changed(rx_clk)
      |-> (run == half - 6'h01)) else $error("rx clock half period off");
   a_rx_clk_stall: assert property (run < half)
      else $error("rx clock stalled");
   a_tx_clk_mii: assert property ((MODE != PMS_MII) |-> !tx_clk)
      else $error("device tx clock outside mii");
endmodule : pms_link_assertions
`default_nettype wire

/* verification/tb.sv */
// self-checking bench joining the transceiver end and the controller end
`timescale 1ns/1ps
`default_nettype none
module tb import pms_pkg::*; ();
   logic clk, rst, full, rx_valid, rx_error, carrier, tx_valid, tx_error;
   logic [7:0] rx_data, mac_data;
   pms_mode_t mode;
   pms_speed_t speed;
   logic phy_take, phy_tx_act, phy_tx_err, mac_take, mac_err, mac_strobe;
   logic mac_col, mac_crs, act_seen, terr_seen, mac_valid;
   int err_count, comparisons, cycles;
   logic [8:0] rxq [$];

   pms_link_if pms_link_if_i ();
   pms_phy_end pms_phy_end_i (.CLK(clk), .RST(rst), .MODE(mode),
      .SPEED(speed), .FULL_DUPLEX(full), .RX_DATA(rx_data),
      .RX_VALID(rx_valid), .RX_ERROR(rx_error), .RX_TAKE(phy_take),
      .LINE_CARRIER(carrier), .TX_ACTIVE(phy_tx_act),
      .TX_ERROR(phy_tx_err), .LINK(pms_link_if_i.phy));
   pms_mac_end pms_mac_end_i (.CLK(clk), .RST(rst), .MODE(mode),
      .SPEED(speed), .FULL_DUPLEX(full), .TX_VALID(tx_valid),
      .TX_ERROR(tx_error), .TX_TAKE(mac_take), .RX_DATA(mac_data),
      .RX_VALID(mac_valid), .RX_ERROR(mac_err), .RX_STROBE(mac_strobe),
      .COL(mac_col), .CRS(mac_crs), .LINK(pms_link_if_i.mac));
   pms_link_assertions pms_link_assertions_i (.CLK(clk), .RST(rst),
      .MODE(mode), .SPEED(speed), .FULL_DUPLEX(full),
      .rx_clk(pms_link_if_i.rx_clk), .rxd(pms_link_if_i.rxd),
      .rx_ctrl(pms_link_if_i.rx_ctrl), .rx_err(pms_link_if_i.rx_err),
      .col(pms_link_if_i.col), .crs(pms_link_if_i.crs),
      .tx_clk(pms_link_if_i.tx_clk), .gtx_clk(pms_link_if_i.gtx_clk),
      .tx_ctrl(pms_link_if_i.tx_ctrl));

   // 100 MHz core clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // captures received bytes and decoded tx flags; cuts a hang short
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (mac_strobe === 1'b1) rxq.push_back({mac_err, mac_data});
      if (phy_tx_act === 1'b1) act_seen <= 1'b1;
      if (phy_tx_err === 1'b1) terr_seen <= 1'b1;
      if (cycles == 30000) begin
         err_count++;
         end_sim();
      end
   end

   task end_sim();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : end_sim

   task chk(input logic [8:0] got, input logic [8:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // mode is only changed under reset, a live change is not supported
   task do_reset(input pms_mode_t m, input pms_speed_t s, input logic f);
      mode <= m;
      speed <= s;
      full <= f;
      rst <= 1'b1;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
   endtask : do_reset

   // bounded wait for the take pulse of one end
   task wait_take(input logic phy_side);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (((phy_side ? phy_take : mac_take) !== 1'b1) && n < 500);
      chk({8'h00, n < 500}, 9'h001);
   endtask : wait_take

   // three bytes across, the middle one flagged as errored
   task test_rx(input pms_mode_t m, input pms_speed_t s);
      logic [7:0] d [0:2];
      d = '{8'hA5, 8'h3C, 8'hF0};
      do_reset(m, s, 1'b1);
      rxq.delete();
      for (int i = 0; i < 3; i++) begin
         rx_data <= d[i];
         rx_error <= (i == 1);
         rx_valid <= 1'b1;
         wait_take(1'b1);
      end
      rx_valid <= 1'b0;
      rx_error <= 1'b0;
      repeat (200) @(posedge clk);
      chk(9'(rxq.size()), 9'h003);
      // valid level of the last event drops once the frame has ended
      chk({8'h00, mac_valid}, 9'h000);
      if (rxq.size() == 3) begin
         for (int i = 0; i < 3; i++) begin
            chk(rxq[i], {i == 1, d[i]});
         end
      end
      $display("test rx done, mode %0d speed %0d", m, s);
   endtask : test_rx

   // enable then an error period; only rgmii folds error onto the line
   task test_tx(input pms_mode_t m, input pms_speed_t s);
      do_reset(m, s, 1'b1);
      act_seen <= 1'b0;
      terr_seen <= 1'b0;
      tx_valid <= 1'b1;
      tx_error <= 1'b0;
      wait_take(1'b0);
      tx_error <= 1'b1;
      wait_take(1'b0);
      tx_error <= 1'b0;
      wait_take(1'b0);
      tx_valid <= 1'b0;
      repeat (80) @(posedge clk);
      chk({7'h00, act_seen, terr_seen}, {7'h00, 1'b1, m == PMS_RGMII});
      chk({8'h00, phy_tx_act}, 9'h000);
      $display("test tx done, mode %0d speed %0d", m, s);
   endtask : test_tx

   // collision and carrier as seen by the controller, then idle again
   task test_cc(input pms_mode_t m, input pms_speed_t s, input logic f,
      input logic car, input logic tx, input logic ecol, input logic ecrs);
      do_reset(m, s, f);
      carrier <= car;
      tx_valid <= tx;
      tx_error <= 1'b0;
      repeat (120) @(posedge clk);
      chk({7'h00, mac_col, mac_crs}, {7'h00, ecol, ecrs});
      carrier <= 1'b0;
      tx_valid <= 1'b0;
      repeat (120) @(posedge clk);
      chk({7'h00, mac_col, mac_crs}, 9'h000);
      $display("test status done, mode %0d full %0d", m, f);
   endtask : test_cc

   // main sequence
   initial begin
      {rst, full, rx_valid, rx_error, carrier, tx_valid, tx_error} = 7'h7F;
      {full, rx_valid, rx_error, carrier, tx_valid, tx_error} = 6'h00;
      rx_data = 8'h00;
      mode = PMS_MII;
      speed = PMS_S100;
      {err_count, comparisons, cycles} = {32'h0, 32'h0, 32'h0};
      act_seen = 1'b0;
      terr_seen = 1'b0;
      test_rx(PMS_MII, PMS_S100);
      test_rx(PMS_GMII, PMS_S1000);
      test_rx(PMS_RGMII, PMS_S1000);
      test_rx(PMS_RGMII, PMS_S10);
      test_tx(PMS_MII, PMS_S100);
      test_tx(PMS_GMII, PMS_S1000);
      test_tx(PMS_RGMII, PMS_S1000);
      test_cc(PMS_MII, PMS_S100, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
      test_cc(PMS_GMII, PMS_S1000, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
      test_cc(PMS_MII, PMS_S10, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
      test_cc(PMS_MII, PMS_S100, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
      test_cc(PMS_GMII, PMS_S1000, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
      test_cc(PMS_RGMII, PMS_S1000, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
      end_sim();
   end
endmodule : tb
`default_nettype wire
